// ===== logic/msg_if.sv
// Signals shared between the recorder and its helpers
`timescale 1ns/1ns
interface msg_if;
	logic [15:0] cw1;
	logic [15:0] cw2;
	logic [15:0] stat;
	logic        stat_seen;
	logic        stat_ok;
	logic        terminal_to_terminal_ok;
	logic        bus_b;
	logic        bmode;
	logic        bcast;
	logic        gap;
	logic        cnt_err;
	logic        rx_err;
	logic        cmd_err;
	logic        stat_err;
	logic [15:0] rx_word;
	logic [15:0] tx_word;
	modport ctrl (output cw1, cw2, stat, stat_seen, stat_ok, terminal_to_terminal_ok, bus_b, bmode, bcast, gap, cnt_err,
		rx_err, input rx_word, tx_word);
	modport chk (input cw1, cw2, stat, stat_seen, stat_ok, output cmd_err, stat_err);
	modport pack (input cw1, cmd_err, stat_err, terminal_to_terminal_ok, bus_b, bmode, bcast, gap, cnt_err, rx_err,
		output rx_word, tx_word);
endinterface

// ===== logic/rt_info_pkg.sv
// Constants for the message information word recorder
package rt_info_pkg;
	// Register map, byte addresses
	localparam int REG_AW = 8;
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_LAST_INFO = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h0C;
	localparam logic [7:0] OFS_IRQ_EN = 8'h10;
	localparam int CFG_BCAST_BIT = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Interrupt status bits
	localparam int IRQ_W = 3;
	localparam int IRQ_MSG = 0;
	localparam int IRQ_TXRT = 1;
	localparam int IRQ_MESSAGE_ERROR_FLAG = 2;
	// Information word fields
	localparam int INFO_GAP = 13;
	localparam int INFO_CNT = 12;
	localparam int INFO_MESSAGE_ERROR_FLAG = 10;
	localparam int INFO_TXRT = 7;
	localparam int INFO_TERMINAL_TO_TERMINAL_OK = 6;
	localparam int INFO_BUS = 5;
	localparam int WC_MSB = 4;
	// Command and status word fields
	localparam int ADDR_MSB = 15;
	localparam int ADDR_LSB = 11;
	localparam int TR_BIT = 10;
	localparam int SA_MSB = 9;
	localparam int SA_LSB = 5;
	localparam logic [4:0] BCAST_ADDR = 5'h1F;
	localparam logic [4:0] MC_SA_LO = 5'h00;
	localparam logic [4:0] MC_SA_HI = 5'h1F;
	// Record layout: info word, time tag, then data
	localparam int TAG_OFS = 1;
	localparam int DATA_OFS = 2;
	typedef enum {S_IDLE, S_ACTIVE, S_INFO, S_TAG} msg_state_e;
endpackage

// ===== logic/rt_msg_info.sv
// Message information word recorder with AXI4-Lite registers
`timescale 1ns/1ns
// Behaviour
// - Flag transmitter error when second command word is broadcast, receive, mode or same address
// - Also flag it for an invalid or misaddressed sender status word
// - Receive bit 6 set only for an error-free RT-RT transfer
// - Bit 5 records the bus: 0 for A, 1 for B
// - Bits 4-0 copy the command word count; zero means 32
// - Two words at record start hold info word and time tag
// - Data pointer marks record start; data fetched after the two words
// - With broadcast mode off, transmit bit 13 flags activity where a gap was due
// - With broadcast mode on, transmit bit 13 flags a broadcast command
// - Transmit bit 12 flags unexpected data words
// - Transmit bit 10 flags any gap or count error
module rt_msg_info #(
	parameter int RAM_AW = 16
) (
	// Clock, reset, enable
	input  wire logic                           aclk,
	input  wire logic                           aresetn,
	input  wire logic                           ce,
	// AXI4-Lite slave
	input  wire logic [rt_info_pkg::REG_AW-1:0] awaddr,
	input  wire logic                           awvalid,
	output logic                                awready,
	input  wire logic [31:0]                    wdata,
	input  wire logic [3:0]                     wstrb,
	input  wire logic                           wvalid,
	output logic                                wready,
	output logic [1:0]                          bresp,
	output logic                                bvalid,
	input  wire logic                           bready,
	input  wire logic [rt_info_pkg::REG_AW-1:0] araddr,
	input  wire logic                           arvalid,
	output logic                                arready,
	output logic [31:0]                         rdata,
	output logic [1:0]                          rresp,
	output logic                                rvalid,
	input  wire logic                           rready,
	// Protocol engine events
	input  wire logic                           msg_start,
	input  wire logic [15:0]                    first_command_word,
	input  wire logic [15:0]                    second_command_word,
	input  wire logic                           msg_terminal_to_terminal_ok,
	input  wire logic                           bus_select_flag,
	input  wire logic                           msg_bcast,
	input  wire logic [RAM_AW-1:0]              msg_ptr,
	input  wire logic                           stat_valid,
	input  wire logic [15:0]                    stat_word,
	input  wire logic                           stat_ok,
	input  wire logic                           gap_seen,
	input  wire logic                           extra_data,
	input  wire logic                           rx_error,
	input  wire logic                           data_next,
	input  wire logic                           msg_done,
	input  wire logic [15:0]                    time_tag,
	// Shared RAM and interrupt
	output logic                                ram_we,
	output logic [RAM_AW-1:0]                   ram_addr,
	output logic [15:0]                         ram_wdata,
	output logic [RAM_AW-1:0]                   fetch_addr,
	output logic                                irq
);
	localparam logic [RAM_AW-1:0] TOFS = RAM_AW'(rt_info_pkg::TAG_OFS);
	localparam logic [RAM_AW-1:0] DOFS = RAM_AW'(rt_info_pkg::DATA_OFS);
	localparam int IW = rt_info_pkg::IRQ_W;

	// Shared RAM address must hold a record
	if (RAM_AW < 4 || RAM_AW > 16)
	begin : g_bad_aw
		$error("RAM_AW must lie between 4 and 16");
	end

	msg_if m ();
	rt_word_check u_check (.m(m.chk));
	rt_word_pack u_pack (.m(m.pack));

	rt_info_pkg::msg_state_e state_q, state_d;
	logic [15:0]        cw1_q, cw1_d, cw2_q, cw2_d, stat_q, stat_d, tag_q, tag_d;
	logic [RAM_AW-1:0]  ptr_q, ptr_d, fetch_q, fetch_d, raddr_q, raddr_d;
	logic               terminal_to_terminal_ok_q, terminal_to_terminal_ok_d, tx_q, tx_d, bus_q, bus_d, bc_q, bc_d, bm_q, bm_d;
	logic               seen_q, seen_d, sok_q, sok_d, gap_q, gap_d, cnt_q, cnt_d, rxe_q, rxe_d;
	logic               we_q, we_d;
	logic [15:0]        wd_q, wd_d, last_q, last_d;
	logic [IW-1:0]      ev;

	// Message fields toward the helpers
	assign m.cw1 = cw1_q;
	assign m.cw2 = cw2_q;
	assign m.stat = stat_q;
	assign m.stat_seen = seen_q;
	assign m.stat_ok = sok_q;
	assign m.terminal_to_terminal_ok = terminal_to_terminal_ok_q; // Both words carry bit 6; the receive word alone is used when tx_q is low
	assign m.bus_b = bus_q;
	assign m.bmode = bm_q;
	assign m.bcast = bc_q;
	assign m.gap = gap_q;
	assign m.cnt_err = cnt_q;
	assign m.rx_err = rxe_q;

	// Register file state
	logic              awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
	logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d, awgot_q, awgot_d, wgot_q, wgot_d;
	logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0]       rdata_q, rdata_d, wdat_q, wdat_d;
	logic [3:0]        wstb_q, wstb_d;
	logic [rt_info_pkg::REG_AW-1:0] waddr_q, waddr_d;
	logic              cfg_q, cfg_d, irq_q, irq_d;
	logic [IW-1:0]     ist_q, ist_d, ien_q, ien_d, clr;

	// Message sequencer: collect events, then write info word and time tag
	always_comb
	begin
		state_d = state_q;
		cw1_d = cw1_q;
		cw2_d = cw2_q;
		stat_d = stat_q;
		tag_d = tag_q;
		ptr_d = ptr_q;
		fetch_d = fetch_q;
		raddr_d = raddr_q;
		terminal_to_terminal_ok_d = terminal_to_terminal_ok_q;
		tx_d = tx_q;
		bus_d = bus_q;
		bc_d = bc_q;
		bm_d = bm_q;
		seen_d = seen_q;
		sok_d = sok_q;
		gap_d = gap_q;
		cnt_d = cnt_q;
		rxe_d = rxe_q;
		we_d = 1'h0;
		wd_d = wd_q;
		last_d = last_q;
		ev = '0;
		unique case (state_q)
			rt_info_pkg::S_IDLE:
			begin
				if (msg_start)
				begin
					cw1_d = first_command_word;
					cw2_d = second_command_word;
					ptr_d = msg_ptr;
					fetch_d = msg_ptr + DOFS;
					terminal_to_terminal_ok_d = msg_terminal_to_terminal_ok;
					tx_d = first_command_word[rt_info_pkg::TR_BIT];
					bus_d = bus_select_flag;
					bc_d = msg_bcast;
					bm_d = cfg_q; // Latched so a mid-message write cannot skew bit 13
					seen_d = 1'h0;
					sok_d = 1'h0;
					gap_d = 1'h0;
					cnt_d = 1'h0;
					rxe_d = 1'h0;
					state_d = rt_info_pkg::S_ACTIVE;
				end
			end
			rt_info_pkg::S_ACTIVE:
			begin
				gap_d = gap_q | gap_seen;
				cnt_d = cnt_q | extra_data;
				rxe_d = rxe_q | rx_error;
				if (stat_valid)
				begin
					stat_d = stat_word;
					sok_d = stat_ok;
					seen_d = 1'h1;
				end
				if (data_next)
					fetch_d = fetch_q + TOFS;
				if (msg_done)
				begin
					tag_d = time_tag;
					state_d = rt_info_pkg::S_INFO;
				end
			end
			rt_info_pkg::S_INFO:
			begin
				we_d = 1'h1;
				raddr_d = ptr_q;
				wd_d = tx_q ? m.tx_word : m.rx_word;
				last_d = wd_d;
				ev[rt_info_pkg::IRQ_MSG] = 1'h1;
				ev[rt_info_pkg::IRQ_TXRT] = !tx_q & m.rx_word[rt_info_pkg::INFO_TXRT];
				ev[rt_info_pkg::IRQ_MESSAGE_ERROR_FLAG] = tx_q & m.tx_word[rt_info_pkg::INFO_MESSAGE_ERROR_FLAG];
				state_d = rt_info_pkg::S_TAG;
			end
			rt_info_pkg::S_TAG:
			begin
				we_d = 1'h1;
				raddr_d = ptr_q + TOFS;
				wd_d = tag_q;
				state_d = rt_info_pkg::S_IDLE;
			end
		endcase
	end

	// Sequencer registers, frozen while ce is low
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q <= rt_info_pkg::S_IDLE;
			{cw1_q, cw2_q, stat_q, tag_q, wd_q, last_q} <= '0;
			{ptr_q, fetch_q, raddr_q} <= '0;
			{terminal_to_terminal_ok_q, tx_q, bus_q, bc_q, bm_q, seen_q, sok_q, gap_q, cnt_q, rxe_q, we_q} <= '0;
		end
		else if (ce)
		begin
			state_q <= state_d;
			{cw1_q, cw2_q, stat_q, tag_q, wd_q, last_q} <= {cw1_d, cw2_d, stat_d, tag_d, wd_d, last_d};
			{ptr_q, fetch_q, raddr_q} <= {ptr_d, fetch_d, raddr_d};
			{terminal_to_terminal_ok_q, tx_q, bus_q, bc_q, bm_q} <= {terminal_to_terminal_ok_d, tx_d, bus_d, bc_d, bm_d};
			{seen_q, sok_q, gap_q, cnt_q, rxe_q, we_q} <= {seen_d, sok_d, gap_d, cnt_d, rxe_d, we_d};
		end
	end

	// Bus slave: one write and one read at a time; writes apply once both halves are in
	always_comb
	begin
		awgot_d = awgot_q;
		wgot_d = wgot_q;
		waddr_d = waddr_q;
		wdat_d = wdat_q;
		wstb_d = wstb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		cfg_d = cfg_q;
		ien_d = ien_q;
		clr = '0;
		if (awvalid && awready_q)
		begin
			awgot_d = 1'h1;
			waddr_d = awaddr;
		end
		if (wvalid && wready_q)
		begin
			wgot_d = 1'h1;
			wdat_d = wdata;
			wstb_d = wstrb;
		end
		if (bvalid_q && bready)
			bvalid_d = 1'h0;
		if (awgot_q && wgot_q && !bvalid_q)
		begin
			awgot_d = 1'h0;
			wgot_d = 1'h0;
			bvalid_d = 1'h1;
			bresp_d = rt_info_pkg::RESP_OKAY;
			case (waddr_q)
				rt_info_pkg::OFS_CONFIG:
					if (wstb_q[0])
						cfg_d = wdat_q[rt_info_pkg::CFG_BCAST_BIT];
				rt_info_pkg::OFS_IRQ_CLR:
					if (wstb_q[0])
						clr = wdat_q[IW-1:0];
				rt_info_pkg::OFS_IRQ_EN:
					if (wstb_q[0])
						ien_d = wdat_q[IW-1:0];
				rt_info_pkg::OFS_LAST_INFO, rt_info_pkg::OFS_IRQ_STAT: ; // Read-only, write ignored
				default:
					bresp_d = rt_info_pkg::RESP_SLVERR;
			endcase
		end
		// Clear first, then set, so a same-cycle event survives
		ist_d = (ist_q & ~clr) | ev;
		if (rvalid_q && rready)
			rvalid_d = 1'h0;
		if (arvalid && arready_q)
		begin
			rvalid_d = 1'h1;
			rresp_d = rt_info_pkg::RESP_OKAY;
			rdata_d = 32'h0000_0000;
			case (araddr)
				rt_info_pkg::OFS_CONFIG: rdata_d[rt_info_pkg::CFG_BCAST_BIT] = cfg_q;
				rt_info_pkg::OFS_LAST_INFO: rdata_d[15:0] = last_q;
				rt_info_pkg::OFS_IRQ_STAT: rdata_d[IW-1:0] = ist_q;
				rt_info_pkg::OFS_IRQ_EN: rdata_d[IW-1:0] = ien_q;
				rt_info_pkg::OFS_IRQ_CLR: ; // Write-only, reads zero
				default: rresp_d = rt_info_pkg::RESP_SLVERR;
			endcase
		end
		awready_d = !awgot_d && !bvalid_d;
		wready_d = !wgot_d && !bvalid_d;
		arready_d = !rvalid_d;
		irq_d = |(ist_d & ien_d);
	end

	// Bus slave registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			{awready_q, wready_q, arready_q} <= '0;
			{awgot_q, wgot_q, bvalid_q, rvalid_q, cfg_q, irq_q} <= '0;
			{bresp_q, rresp_q, rdata_q, wdat_q, wstb_q, waddr_q} <= '0;
			{ist_q, ien_q} <= '0;
		end
		else if (ce)
		begin
			{awready_q, wready_q, arready_q} <= {awready_d, wready_d, arready_d};
			{awgot_q, wgot_q, bvalid_q, rvalid_q} <= {awgot_d, wgot_d, bvalid_d, rvalid_d};
			{cfg_q, irq_q, ist_q, ien_q} <= {cfg_d, irq_d, ist_d, ien_d};
			{bresp_q, rresp_q, rdata_q} <= {bresp_d, rresp_d, rdata_d};
			{wdat_q, wstb_q, waddr_q} <= {wdat_d, wstb_d, waddr_d};
		end
	end

	// Outputs straight from flops
	assign {awready, wready, arready} = {awready_q, wready_q, arready_q};
	assign {bresp, bvalid, rdata, rresp, rvalid} = {bresp_q, bvalid_q, rdata_q, rresp_q, rvalid_q};
	assign {ram_we, ram_addr, ram_wdata} = {we_q, raddr_q, wd_q};
	assign fetch_addr = fetch_q;
	assign irq = irq_q;

	// Checks; in S_TAG the info word sits on the RAM port
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_TXERR_CMD: assert property (state_q == rt_info_pkg::S_TAG && terminal_to_terminal_ok_q && !tx_q
		&& cw2_q[rt_info_pkg::ADDR_MSB:rt_info_pkg::ADDR_LSB] == rt_info_pkg::BCAST_ADDR
		|-> ram_wdata[rt_info_pkg::INFO_TXRT]) else $error("transmitter error not flagged");
	AST_TXERR_STAT: assert property (state_q == rt_info_pkg::S_TAG && terminal_to_terminal_ok_q && !tx_q && seen_q
		&& !sok_q |-> ram_wdata[rt_info_pkg::INFO_TXRT]) else $error("bad status not flagged");
	AST_TERMINAL_TO_TERMINAL_OK_OK: assert property (state_q == rt_info_pkg::S_TAG && ram_wdata[rt_info_pkg::INFO_TERMINAL_TO_TERMINAL_OK]
		|-> terminal_to_terminal_ok_q && !gap_q && !cnt_q) else $error("RT-RT ok set despite error");
	AST_BUS_WC: assert property (state_q == rt_info_pkg::S_TAG |-> ram_we
		&& ram_wdata[rt_info_pkg::INFO_BUS] == bus_q && ram_wdata[4:0] == cw1_q[4:0])
		else $error("bus or word count wrong");
	AST_LAYOUT: assert property (ce && state_q == rt_info_pkg::S_TAG |=> ram_we
		&& ram_addr == $past(ram_addr) + TOFS && ram_wdata == tag_q) else $error("time tag misplaced");
	AST_FETCH: assert property (ce && state_q == rt_info_pkg::S_IDLE && msg_start
		|=> fetch_addr == $past(msg_ptr) + DOFS) else $error("fetch not past reserved words");
	AST_GAP_BC: assert property (state_q == rt_info_pkg::S_TAG && tx_q
		|-> ram_wdata[rt_info_pkg::INFO_GAP] == (bm_q ? bc_q : gap_q)) else $error("bit 13 wrong");
	AST_MESSAGE_ERROR_FLAG: assert property (state_q == rt_info_pkg::S_TAG && tx_q |->
		ram_wdata[rt_info_pkg::INFO_CNT] == cnt_q && ram_wdata[rt_info_pkg::INFO_MESSAGE_ERROR_FLAG] == (gap_q | cnt_q))
		else $error("count or message error wrong");
	AST_ZERO: assert property (state_q == rt_info_pkg::S_TAG && tx_q |->
		ram_wdata[15:14] == 2'h0 && !ram_wdata[11] && !ram_wdata[7]) else $error("unused bits set");
	AST_IRQ: assert property (ce && state_q == rt_info_pkg::S_INFO && ien_q[rt_info_pkg::IRQ_MSG]
		|=> irq) else $error("interrupt not raised");
	COV_RX_OK: cover property (state_q == rt_info_pkg::S_TAG && ram_wdata[rt_info_pkg::INFO_TERMINAL_TO_TERMINAL_OK]);
	COV_TX_GAP: cover property (state_q == rt_info_pkg::S_TAG && tx_q && ram_wdata[rt_info_pkg::INFO_MESSAGE_ERROR_FLAG]);
	COV_WRITE: cover property (bvalid && bready);
endmodule // rt_msg_info

// ===== logic/rt_word_check.sv
// Checks of the second command word and the sender's status word
`timescale 1ns/1ns
module rt_word_check (
	msg_if.chk m
);
	logic [4:0] a1;
	logic [4:0] a2;
	logic [4:0] sa;

	// Field extraction
	assign a1 = m.cw1[rt_info_pkg::ADDR_MSB:rt_info_pkg::ADDR_LSB];
	assign a2 = m.cw2[rt_info_pkg::ADDR_MSB:rt_info_pkg::ADDR_LSB];
	assign sa = m.cw2[rt_info_pkg::SA_MSB:rt_info_pkg::SA_LSB];

	// Any one of four faults in the second word
	assign m.cmd_err = (a2 == rt_info_pkg::BCAST_ADDR)
		| !m.cw2[rt_info_pkg::TR_BIT]
		| (sa == rt_info_pkg::MC_SA_LO) | (sa == rt_info_pkg::MC_SA_HI)
		| ((a2 == a1) & (a1 != rt_info_pkg::BCAST_ADDR));

	// Bad or misaddressed status word; a missing one is a timeout, not ours
	assign m.stat_err = m.stat_seen & (!m.stat_ok
		| (m.stat[rt_info_pkg::ADDR_MSB:rt_info_pkg::ADDR_LSB] != a2));
endmodule // rt_word_check

// ===== logic/rt_word_pack.sv
// Packs the receive and transmit information words
`timescale 1ns/1ns
module rt_word_pack (
	msg_if.pack m
);
	logic txerr;
	logic clean;

	// Transmitter fault only matters for a receive RT-RT command
	assign txerr = m.terminal_to_terminal_ok & (m.cmd_err | m.stat_err);
	assign clean = !m.gap & !m.cnt_err;

	// Receive word; upper error bits belong elsewhere and stay zero
	always_comb
	begin
		m.rx_word = 16'h0000;
		m.rx_word[rt_info_pkg::INFO_TXRT] = txerr;
		m.rx_word[rt_info_pkg::INFO_TERMINAL_TO_TERMINAL_OK] = m.terminal_to_terminal_ok & !txerr & !m.rx_err & clean;
		m.rx_word[rt_info_pkg::INFO_BUS] = m.bus_b;
		m.rx_word[rt_info_pkg::WC_MSB:0] = m.cw1[rt_info_pkg::WC_MSB:0];
	end

	// Transmit word; bits 15, 14, 11 and 7 stay zero
	always_comb
	begin
		m.tx_word = 16'h0000;
		m.tx_word[rt_info_pkg::INFO_GAP] = m.bmode ? m.bcast : m.gap;
		m.tx_word[rt_info_pkg::INFO_CNT] = m.cnt_err;
		m.tx_word[rt_info_pkg::INFO_MESSAGE_ERROR_FLAG] = m.gap | m.cnt_err;
		m.tx_word[rt_info_pkg::INFO_TERMINAL_TO_TERMINAL_OK] = m.terminal_to_terminal_ok & clean;
		m.tx_word[rt_info_pkg::INFO_BUS] = m.bus_b;
		m.tx_word[rt_info_pkg::WC_MSB:0] = m.cw1[rt_info_pkg::WC_MSB:0];
	end
endmodule // rt_word_pack

// ===== tb/rt_engine_model.sv
// Protocol engine and host shared RAM facing the recorder
`timescale 1ns/1ns
package tb_msg_pkg;
	typedef struct packed {
		logic [15:0] cw1, cw2, st, tag;
		logic [7:0]  ptr;
		logic        terminal_to_terminal_ok, bus, bc, sv, sok, gap, ext, rxe;
	} msg_s;
endpackage

module rt_engine_model (
	// Clock
	input  wire logic        aclk,
	// Message link to the recorder
	output logic             msg_start,
	output logic [15:0]      first_command_word,
	output logic [15:0]      second_command_word,
	output logic             msg_terminal_to_terminal_ok,
	output logic             bus_select_flag,
	output logic             msg_bcast,
	output logic [7:0]       msg_ptr,
	output logic             stat_valid,
	output logic [15:0]      stat_word,
	output logic             stat_ok,
	output logic             gap_seen,
	output logic             extra_data,
	output logic             rx_error,
	output logic             data_next,
	output logic             msg_done,
	output logic [15:0]      time_tag,
	// Shared RAM write port
	input  wire logic        ram_we,
	input  wire logic [7:0]  ram_addr,
	input  wire logic [15:0] ram_wdata
);
	logic [15:0] mem [256];

	// Link idle at time zero
	initial
	begin
		{msg_start, msg_terminal_to_terminal_ok, bus_select_flag, msg_bcast, stat_valid, stat_ok, msg_ptr} = '0;
		{gap_seen, extra_data, rx_error, data_next, msg_done} = '0;
		{first_command_word, second_command_word, stat_word, time_tag} = '0;
	end

	// Shared RAM takes what the recorder stores
	always @(posedge aclk)
		if (ram_we)
			mem[ram_addr] <= ram_wdata;

	// One message: start, one event cycle, done, then the busy tail
	task automatic send(input tb_msg_pkg::msg_s m);
		mem[m.ptr + 8'h02] = 16'hD000 | m.ptr; // Host loads data past two free words
		@(posedge aclk);
		{msg_start, first_command_word, second_command_word} <= {1'b1, m.cw1, m.cw2};
		{msg_terminal_to_terminal_ok, bus_select_flag, msg_bcast, msg_ptr} <= {m.terminal_to_terminal_ok, m.bus, m.bc, m.ptr};
		@(posedge aclk);
		// Words only hold meaning with the start pulse, so scramble them after
		{msg_start, first_command_word, second_command_word} <= {1'b0, ~m.cw1, ~m.cw2};
		msg_ptr <= ~m.ptr;
		{stat_valid, stat_word, stat_ok} <= {m.sv, m.st, m.sok};
		{gap_seen, extra_data, rx_error, data_next} <= {m.gap, m.ext, m.rxe, 1'b1};
		@(posedge aclk);
		{stat_valid, gap_seen, extra_data, rx_error, data_next} <= '0;
		{stat_word, stat_ok} <= {~m.st, ~m.sok};
		{msg_done, time_tag} <= {1'b1, m.tag};
		@(posedge aclk);
		{msg_done, time_tag} <= {1'b0, ~m.tag};
		repeat (4) @(posedge aclk); // Recorder stays busy after done
	endtask
endmodule // rt_engine_model

// ===== tb/rt_msg_info_tb_top.sv
// Self-checking bench for the message information word recorder
`timescale 1ns/1ns
module rt_msg_info_tb_top;
	// Clock, reset and register bus
	logic        aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  resp;
	wire         awready, wready, bvalid, arready, rvalid, irq, ram_we;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	// Message link and shared RAM
	wire         msg_start, msg_terminal_to_terminal_ok, bus_select_flag, msg_bcast, stat_valid, stat_ok;
	wire         gap_seen, extra_data, rx_error, data_next, msg_done;
	wire  [15:0] first_command_word, second_command_word, stat_word, time_tag, ram_wdata;
	wire  [7:0]  msg_ptr, ram_addr, fetch_addr;
	int          n_mismatch, checks;

	rt_msg_info #(.RAM_AW(8)) DUT (
		.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.msg_start, .first_command_word, .second_command_word, .msg_terminal_to_terminal_ok, .bus_select_flag,
		.msg_bcast, .msg_ptr, .stat_valid, .stat_word, .stat_ok, .gap_seen, .extra_data,
		.rx_error, .data_next, .msg_done, .time_tag, .ram_we, .ram_addr, .ram_wdata, .fetch_addr, .irq
	);
	rt_engine_model ENG (
		.aclk, .msg_start, .first_command_word, .second_command_word, .msg_terminal_to_terminal_ok, .bus_select_flag,
		.msg_bcast, .msg_ptr, .stat_valid, .stat_word, .stat_ok, .gap_seen, .extra_data, .rx_error,
		.data_next, .msg_done, .time_tag, .ram_we, .ram_addr, .ram_wdata
	);

	// 25 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic close_out();
		if (n_mismatch == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Write: address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic ad, wd;
		{ad, wd} = 2'b00;
		@(posedge aclk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
		while (!(ad && wd))
		begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
			ad = ad | (awready === 1'b1);
			wd = wd | (wready === 1'b1);
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a);
		@(posedge aclk);
		{araddr, arvalid, rready} <= {a, 2'b11};
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		{rd, resp} = {rdata, rresp};
		rready <= 1'b0;
	endtask

	// Expected word; unused bits stay zero
	function automatic logic [15:0] exp_info(input tb_msg_pkg::msg_s m, input logic bm);
		logic [15:0] w;
		logic        e;
		logic [4:0]  a1, a2, sa;
		w = {10'h000, m.bus, m.cw1[4:0]};
		{a1, a2, sa} = {m.cw1[15:11], m.cw2[15:11], m.cw2[9:5]};
		if (m.cw1[10])
		begin
			e = m.gap | m.ext;
			{w[13], w[12], w[10], w[6]} = {bm ? m.bc : m.gap, m.ext, e, m.terminal_to_terminal_ok & !e};
		end
		else
		begin
			e = (a2 == 5'h1F) | !m.cw2[10] | (sa == 5'h00) | (sa == 5'h1F) | ((a2 == a1) & (a1 != 5'h1F));
			e = m.terminal_to_terminal_ok & (e | (m.sv & (!m.sok | (m.st[15:11] != a2))));
			{w[7], w[6]} = {e, m.terminal_to_terminal_ok & !e & !m.rxe};
		end
		return w;
	endfunction

	// Send one message and judge what lands in shared RAM
	task automatic msg_chk(input tb_msg_pkg::msg_s m, input logic bm);
		ENG.send(m);
		chk("info word", exp_info(m, bm), ENG.mem[m.ptr]);
		chk("time tag", m.tag, ENG.mem[m.ptr + 8'h01]);
		chk("data word", 16'hD000 | m.ptr, ENG.mem[m.ptr + 8'h02]);
		chk("fetch address", m.ptr + 8'h03, fetch_addr);
	endtask

	// Idle outputs and register values after release
	task automatic t_reset();
		chk("idle outputs", 32'h0, {irq, ram_we, bvalid, rvalid, fetch_addr});
		for (int i = 0; i < 5; i++)
		begin
			axi_rd(8'(i * 4));
			chk("reset value", 32'h0, rd);
		end
	endtask

	// Receive: clean RT-RT, each sender fault, then a plain transfer on bus B
	task automatic t_receive();
		tb_msg_pkg::msg_s m;
		for (int i = 0; i < 10; i++)
		begin
			m = '{cw1: 16'h2843, cw2: 16'h4C83, st: 16'h4800, tag: 16'(16'h7100 + i),
				ptr: 8'(i * 4), terminal_to_terminal_ok: 1'b1, sv: 1'b1, sok: 1'b1, default: '0};
			case (i)
				1: m.cw2[15:11] = 5'h1F;
				2: m.cw2[10] = 1'b0;
				3: m.cw2[9:5] = 5'h00;
				4: m.cw2[9:5] = 5'h1F;
				5: m.cw2[15:11] = 5'h05;
				6: m.sok = 1'b0;
				7: m.st[15:11] = 5'h03;
				8: m.rxe = 1'b1;
				9: {m.terminal_to_terminal_ok, m.bus, m.cw1[4:0]} = 7'h20;
				default: ;
			endcase
			msg_chk(m, 1'b0);
		end
	endtask

	// Transmit: gap and count faults, then broadcast mode on
	task automatic t_transmit();
		tb_msg_pkg::msg_s m;
		for (int i = 0; i < 6; i++)
		begin
			m = '{cw1: 16'h2C45, tag: 16'(16'h7200 + i), ptr: 8'(8'h80 + i * 4), terminal_to_terminal_ok: 1'b1, default: '0};
			{m.gap, m.ext} = (i < 4) ? 2'(i) : {i == 5, 1'b0};
			m.bc = (i == 4);
			if (i == 4)
				axi_wr(rt_info_pkg::OFS_CONFIG, 32'h1 << rt_info_pkg::CFG_BCAST_BIT);
			msg_chk(m, i >= 4);
		end
		axi_wr(rt_info_pkg::OFS_CONFIG, 32'h0);
	endtask

	// Interrupt: set while masked, raised by enable, dropped by clear
	task automatic t_irq();
		tb_msg_pkg::msg_s m;
		axi_wr(rt_info_pkg::OFS_IRQ_CLR, 32'h7);
		axi_rd(rt_info_pkg::OFS_IRQ_STAT);
		chk("status cleared", 32'h0, rd);
		m = '{cw1: 16'h2843, cw2: 16'hFC83, st: 16'hF800, tag: 16'h7300, ptr: 8'hC0, terminal_to_terminal_ok: 1'b1,
			sv: 1'b1, sok: 1'b1, default: '0};
		msg_chk(m, 1'b0);
		axi_rd(rt_info_pkg::OFS_IRQ_STAT);
		chk("status set", 32'h3, rd);
		chk("masked irq", 32'h0, irq);
		axi_wr(rt_info_pkg::OFS_IRQ_EN, 32'h2);
		repeat (2) @(posedge aclk);
		chk("enabled irq", 32'h1, irq);
		axi_wr(rt_info_pkg::OFS_LAST_INFO, 32'hFFFF);
		axi_rd(rt_info_pkg::OFS_LAST_INFO);
		chk("last info", exp_info(m, 1'b0), rd);
		axi_wr(rt_info_pkg::OFS_IRQ_CLR, 32'h2);
		repeat (2) @(posedge aclk);
		chk("cleared irq", 32'h0, irq);
		axi_rd(rt_info_pkg::OFS_IRQ_STAT);
		chk("status left", 32'h1, rd);
		axi_rd(8'h14);
		chk("unmapped read", {30'h0, rt_info_pkg::RESP_SLVERR}, {rd[29:0], resp});
		axi_wr(8'h14, 32'h1);
		chk("unmapped write", rt_info_pkg::RESP_SLVERR, resp);
	endtask

	// Main sequence
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		{wstrb, ce, n_mismatch, checks} = {4'hF, 1'b1, 64'h0};
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_receive();
		t_transmit();
		t_irq();
		close_out();
	end

	// Watchdog, far beyond the few hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		close_out();
	end
endmodule // rt_msg_info_tb_top
